// ===== hw/keypad_setup_pkg.sv
// Constants, register map and state codes of the keypad and setup menu controller
// Operation
// R01: On/off key toggles release in keypad mode
// R02: Long OK hold saves parameters, flashes twice
// R03: Long minus+plus+OK hold restores factory values
// R04: Acknowledge combo flashes, checks system, lights status
// R05: Each acknowledge clears only one pending fault
// R06: Menu entry needs voltage/frequency/balance display, setup hold
// R07: OK confirms and advances; no cancel path
// R08: Fixed item order; config LEDs mark items
// R09: Software release option has five values
// R10: Hardware release item: disabled or enabled
// R11: Signal output: HV active, warning, pollution
// R12: Sensor input: off or speed sensor
// R13: Fieldbus items only on fieldbus variants
// R14: Node address entered as tens then ones
// R15: Baud positions select rates; nine disables bus
// R16: Exit clamps, saves, flashes twice, returns
// R17: Address and baud apply after restart only
// R18: Indicators show item, bar shows value
// R19: Hold threshold is configurable
package keypad_setup_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int HOLD_MS = 2000;                       // Long-press time in ms
  localparam int FLASH_MS = 250;                       // One flash phase in ms
  localparam int HOLD_CYCLES = HOLD_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYCLES = FLASH_MS * (CLK_HZ / 1000);
  // Key bit positions in the key vector
  localparam int KEY_N = 6;
  localparam int KEY_PLUS = 0;
  localparam int KEY_MINUS = 1;
  localparam int KEY_OK = 2;
  localparam int KEY_SETUP = 3;
  localparam int KEY_DSEL = 4;
  localparam int KEY_ONOFF = 5;
  localparam logic [5:0] COMBO_SAVE = 6'h04;
  localparam logic [5:0] COMBO_FACTORY = 6'h07;
  localparam logic [5:0] COMBO_ACK = 6'h1C;
  localparam logic [5:0] COMBO_SETUP = 6'h08;
  localparam int BAR_N = 10;
  // Display modes of the bar
  localparam logic [1:0] DISP_VOLT = 2'h0;
  localparam logic [1:0] DISP_POLL = 2'h2;
  // Largest index of each menu value (position minus one)
  localparam logic [3:0] MAX_SW = 4'h4;
  localparam logic [3:0] MAX_HW = 4'h1;
  localparam logic [3:0] MAX_SIG = 4'h2;
  localparam logic [3:0] MAX_SEN = 4'h1;
  localparam logic [3:0] MAX_DIGIT = 4'h9;
  localparam logic [3:0] MAX_BAUD = 4'h8;               // Index 8 = bus disabled
  localparam logic [6:0] DIGIT_WEIGHT = 7'h0A;
  // Software release option codes
  localparam logic [2:0] SW_OFF = 3'h0;
  localparam logic [2:0] SW_AUTO = 3'h1;
  localparam logic [2:0] SW_KEYPAD = 3'h2;
  // Factory values
  localparam logic [2:0] DEF_SW = SW_KEYPAD;
  localparam logic [3:0] DEF_BAUD = 4'h3;
  localparam logic [6:0] DEF_NODE = 7'h01;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_BUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;
  localparam logic [7:0] REG_HOLD = 8'h18;
  // CTRL fields: variant bits, fieldbus release, restart apply
  localparam int CTRL_HAS_HW = 0;
  localparam int CTRL_HAS_SIG = 1;
  localparam int CTRL_HAS_SEN = 2;
  localparam int CTRL_HAS_CAN = 3;
  localparam int CTRL_FB_REL = 4;
  localparam int CTRL_RESTART = 5;
  localparam logic [4:0] CTRL_RESET = 5'h0F;
  // Interrupt event bits
  localparam int EV_SAVE = 0;
  localparam int EV_FACTORY = 1;
  localparam int EV_ACK = 2;
  localparam int EV_EXIT = 3;
  // Actions tied to a double flash; exit work runs as the flash starts, the others after it
  typedef enum logic [3:0] {
    ACT_SAVE = 4'h1,
    ACT_FACTORY = 4'h2,
    ACT_ACK = 4'h4,
    ACT_EXIT = 4'h8
  } act_t;
  typedef enum logic [9:0] {
    ST_NORMAL = 10'h001,
    ST_ENTERED = 10'h002,
    ST_SW = 10'h004,
    ST_HW = 10'h008,
    ST_SIG = 10'h010,
    ST_SEN = 10'h020,
    ST_TENS = 10'h040,
    ST_ONES = 10'h080,
    ST_BAUD = 10'h100,
    ST_FLASH = 10'h200
  } menu_t;
endpackage

// ===== hw/keypad_setup_menu_controller.sv
// Keypad combination handler, device settings menu, LED drive and register port
module keypad_setup_menu_controller #(
  parameter int HOLD_DEFAULT = keypad_setup_pkg::HOLD_CYCLES,
  parameter int FLASH_LEN = keypad_setup_pkg::FLASH_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic keyPlusPin,
  input wire logic keyMinusPin,
  input wire logic keyOkPin,
  input wire logic keySetupPin,
  input wire logic displaySelectKeyPin,
  input wire logic keyOnOffPin,
  input wire logic faultRaise,
  input wire logic sysCheckOk,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic [keypad_setup_pkg::BAR_N-1:0] ledBar,
  output logic [3:0] cfgLed,
  output logic [3:0] modeLed,
  output logic setupLed,
  output logic busLed,
  output logic statusLed,
  output logic hvRelease,
  output logic hwReleaseEn,
  output logic [1:0] signalOutMode,
  output logic sensorInMode,
  output logic [6:0] nodeAddr,
  output logic [3:0] baudSel,
  output logic savePulse,
  output logic factoryPulse,
  output logic irq
);
  import keypad_setup_pkg::*;

  typedef struct packed {
    logic [5:0] keyMeta;
    logic [5:0] keySync;
    logic [5:0] keyPrev;
    logic [31:0] holdCnt;
    logic holdFired;
    logic [31:0] holdLimit;
    menu_t menu;
    act_t act;
    logic [31:0] flashCnt;
    logic [1:0] flashPhase;
    logic [3:0] edit;
    logic [1:0] dispMode;
    logic [2:0] swOpt;
    logic hwRel;
    logic [1:0] sigMode;
    logic sensor;
    logic [3:0] wSw;
    logic [3:0] wHw;
    logic [3:0] wSig;
    logic [3:0] wSen;
    logic [3:0] wTens;
    logic [3:0] wOnes;
    logic [3:0] wBaud;
    logic [6:0] savedNode;
    logic [3:0] savedBaud;
    logic [6:0] node;
    logic [3:0] baud;
    logic keyRelease;
    logic [3:0] faults;
    logic status;
    logic [5:0] ctrl;
    logic [3:0] irqStat;
    logic [3:0] irqMask;
    logic [31:0] rdata;
    logic [BAR_N-1:0] bar;
    logic [3:0] cfg;
    logic [3:0] mode;
    logic setup;
    logic bus;
    logic hv;
    logic save;
    logic factory;
    logic irqOut;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [1:0] rstSync_r;
  logic rstn;

  // Reset is asserted at once and released two edges later
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstn = rstSync_r[1];

  // Clamp a value to its largest allowed index
  function automatic logic [3:0] clampTo(input logic [3:0] v, input logic [3:0] mx);
    clampTo = (v > mx) ? mx : v;
  endfunction

  // Largest editable index of the item shown in a state
  function automatic logic [3:0] itemMax(input menu_t m);
    case (m)
      ST_SW: itemMax = MAX_SW;
      ST_HW: itemMax = MAX_HW;
      ST_SIG: itemMax = MAX_SIG;
      ST_SEN: itemMax = MAX_SEN;
      ST_TENS, ST_ONES: itemMax = MAX_DIGIT;
      ST_BAUD: itemMax = MAX_BAUD;
      default: itemMax = 4'h0;
    endcase
  endfunction

  // Next state of the whole block
  always_comb begin
    logic [5:0] keys;
    logic [5:0] pressed;
    logic holdHit;
    logic flashEnd;
    logic [3:0] ev;
    keys = st_r.keySync;
    pressed = 6'h00;
    holdHit = 1'b0;
    flashEnd = 1'b0;
    ev = 4'h0;
    st_nxt = st_r;
    st_nxt.save = 1'b0;
    st_nxt.factory = 1'b0;
    st_nxt.ctrl[CTRL_RESTART] = 1'b0;
    // Pins pass two flops; only the second is read by logic
    st_nxt.keyMeta = {keyOnOffPin, displaySelectKeyPin, keySetupPin, keyOkPin, keyMinusPin, keyPlusPin};
    st_nxt.keySync = st_r.keyMeta;
    st_nxt.keyPrev = keys;
    pressed = keys & ~st_r.keyPrev;
    // One hold counter for the exact key set held; a change restarts it
    if (keys != st_r.keyPrev || keys == 6'h00) begin
      st_nxt.holdCnt = 32'h0;
      st_nxt.holdFired = 1'b0;
    end else if (!st_r.holdFired) begin
      if (st_r.holdCnt >= st_r.holdLimit) begin // R19
        holdHit = 1'b1;
        st_nxt.holdFired = 1'b1; // Fires once per hold
      end else begin
        st_nxt.holdCnt = st_r.holdCnt + 32'h1;
      end
    end
    // Faults arrive from the supervisor; saturate rather than wrap
    if (faultRaise && st_r.faults != 4'hF) begin
      st_nxt.faults = st_r.faults + 4'h1;
      st_nxt.status = 1'b0;
    end
    case (st_r.menu)
      ST_NORMAL: begin
        if (pressed[KEY_DSEL] && keys == COMBO_SETUP << 1) begin
          st_nxt.dispMode = st_r.dispMode + 2'h1;
        end
        if (pressed[KEY_ONOFF] && st_r.swOpt == SW_KEYPAD) begin
          st_nxt.keyRelease = ~st_r.keyRelease; // R01
        end
        if (holdHit) begin
          case (keys)
            COMBO_SAVE: begin
              st_nxt.act = ACT_SAVE; // R02
              st_nxt.menu = ST_FLASH;
            end
            COMBO_FACTORY: begin
              st_nxt.act = ACT_FACTORY; // R03
              st_nxt.menu = ST_FLASH;
            end
            COMBO_ACK: begin
              st_nxt.act = ACT_ACK; // R04
              st_nxt.menu = ST_FLASH;
            end
            COMBO_SETUP: begin
              if (st_r.dispMode != DISP_POLL) begin
                st_nxt.menu = ST_ENTERED; // R06
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_ENTERED: begin
        // Working copies start from the live settings; address and baud from their saved values
        if (pressed[KEY_OK]) begin
          st_nxt.wSw = {1'b0, st_r.swOpt};
          st_nxt.wHw = {3'h0, st_r.hwRel};
          st_nxt.wSig = {2'h0, st_r.sigMode};
          st_nxt.wSen = {3'h0, st_r.sensor};
          st_nxt.wTens = 4'(st_r.savedNode / DIGIT_WEIGHT);
          st_nxt.wOnes = 4'(st_r.savedNode % DIGIT_WEIGHT);
          st_nxt.wBaud = st_r.savedBaud;
          st_nxt.edit = {1'b0, st_r.swOpt};
          st_nxt.menu = ST_SW; // R08
        end
      end
      ST_SW, ST_HW, ST_SIG, ST_SEN, ST_TENS, ST_ONES, ST_BAUD: begin
        // Plus and minus step the shown value within its range
        if (pressed[KEY_PLUS] && st_r.edit < itemMax(st_r.menu)) begin
          st_nxt.edit = st_r.edit + 4'h1; // R18
        end else if (pressed[KEY_MINUS] && st_r.edit != 4'h0) begin
          st_nxt.edit = st_r.edit - 4'h1; // R18
        end
        // OK stores the value and advances; the menu has no way out but forward
        if (pressed[KEY_OK]) begin // R07
          case (st_r.menu)
            ST_SW: begin
              st_nxt.wSw = st_r.edit; // R09
              st_nxt.menu = st_r.ctrl[CTRL_HAS_HW] ? ST_HW : st_r.ctrl[CTRL_HAS_SIG] ? ST_SIG :
                            st_r.ctrl[CTRL_HAS_SEN] ? ST_SEN : st_r.ctrl[CTRL_HAS_CAN] ? ST_TENS : ST_FLASH;
            end
            ST_HW: begin
              st_nxt.wHw = st_r.edit; // R10
              st_nxt.menu = st_r.ctrl[CTRL_HAS_SIG] ? ST_SIG : st_r.ctrl[CTRL_HAS_SEN] ? ST_SEN :
                            st_r.ctrl[CTRL_HAS_CAN] ? ST_TENS : ST_FLASH;
            end
            ST_SIG: begin
              st_nxt.wSig = st_r.edit; // R11
              st_nxt.menu = st_r.ctrl[CTRL_HAS_SEN] ? ST_SEN : st_r.ctrl[CTRL_HAS_CAN] ? ST_TENS : ST_FLASH;
            end
            ST_SEN: begin
              st_nxt.wSen = st_r.edit; // R12
              st_nxt.menu = st_r.ctrl[CTRL_HAS_CAN] ? ST_TENS : ST_FLASH; // R13
            end
            ST_TENS: begin
              st_nxt.wTens = st_r.edit; // R14
              st_nxt.menu = ST_ONES;
            end
            ST_ONES: begin
              st_nxt.wOnes = st_r.edit; // R14
              st_nxt.menu = ST_BAUD;
            end
            default: begin
              st_nxt.wBaud = st_r.edit; // R15
              st_nxt.menu = ST_FLASH;
            end
          endcase
          // Load the next item's current value into the editor
          case (st_nxt.menu)
            ST_HW: st_nxt.edit = st_r.wHw;
            ST_SIG: st_nxt.edit = st_r.wSig;
            ST_SEN: st_nxt.edit = st_r.wSen;
            ST_TENS: st_nxt.edit = st_r.wTens;
            ST_ONES: st_nxt.edit = st_r.wOnes;
            ST_BAUD: st_nxt.edit = st_r.wBaud;
            default: st_nxt.edit = 4'h0;
          endcase
          if (st_nxt.menu == ST_FLASH) begin
            st_nxt.act = ACT_EXIT;
          end
        end
      end
      ST_FLASH: begin
        // Two flashes: off, on, off, on phases of equal length
        if (st_r.flashCnt >= 32'(FLASH_LEN - 1)) begin
          st_nxt.flashCnt = 32'h0;
          st_nxt.flashPhase = st_r.flashPhase + 2'h1;
          flashEnd = (st_r.flashPhase == 2'h3);
        end else begin
          st_nxt.flashCnt = st_r.flashCnt + 32'h1;
        end
        // Exit work is done as the flashing starts so settings apply on leaving
        if (st_r.flashCnt == 32'h0 && st_r.flashPhase == 2'h0 && st_r.act == ACT_EXIT) begin
          st_nxt.swOpt = 3'(clampTo(st_r.wSw, MAX_SW)); // R16
          st_nxt.hwRel = clampTo(st_r.wHw, MAX_HW) != 4'h0; // R16
          st_nxt.sigMode = 2'(clampTo(st_r.wSig, MAX_SIG)); // R16
          st_nxt.sensor = clampTo(st_r.wSen, MAX_SEN) != 4'h0; // R16
          st_nxt.savedNode = 7'(clampTo(st_r.wTens, MAX_DIGIT)) * DIGIT_WEIGHT
                             + 7'(clampTo(st_r.wOnes, MAX_DIGIT)); // R14
          st_nxt.savedBaud = clampTo(st_r.wBaud, MAX_BAUD); // R16
          st_nxt.save = 1'b1; // R16
          ev[EV_EXIT] = 1'b1;
        end
        if (flashEnd) begin
          st_nxt.menu = ST_NORMAL;
          case (st_r.act)
            ACT_SAVE: begin
              st_nxt.save = 1'b1; // R02
              ev[EV_SAVE] = 1'b1;
            end
            ACT_FACTORY: begin
              st_nxt.swOpt = DEF_SW; // R03
              st_nxt.hwRel = 1'b0;
              st_nxt.sigMode = 2'h0;
              st_nxt.sensor = 1'b0;
              st_nxt.savedNode = DEF_NODE;
              st_nxt.savedBaud = DEF_BAUD;
              st_nxt.factory = 1'b1;
              ev[EV_FACTORY] = 1'b1;
            end
            ACT_ACK: begin
              // Only one pending message goes per acknowledge, and only after the check
              if (sysCheckOk && st_r.faults != 4'h0 && !faultRaise) begin
                st_nxt.faults = st_r.faults - 4'h1; // R05
                st_nxt.status = 1'b1; // R04
                ev[EV_ACK] = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      default: st_nxt.menu = ST_NORMAL;
    endcase
    // Address and baud go live only on a restart request
    if (st_r.ctrl[CTRL_RESTART]) begin
      st_nxt.node = st_r.savedNode; // R17
      st_nxt.baud = st_r.savedBaud; // R17
    end
    // Register writes; a write-one clear loses to a same-cycle event
    st_nxt.rdata = 32'h0;
    if (regWr) begin
      case (regAddr)
        REG_CTRL: st_nxt.ctrl = {regWrData[CTRL_RESTART], regWrData[CTRL_FB_REL:0]};
        REG_IRQ_STAT: st_nxt.irqStat = st_r.irqStat & ~regWrData[3:0];
        REG_IRQ_MASK: st_nxt.irqMask = regWrData[3:0];
        REG_HOLD: st_nxt.holdLimit = regWrData;
        default: begin
        end
      endcase
    end
    st_nxt.irqStat = st_nxt.irqStat | ev;
    if (regRd) begin
      case (regAddr)
        REG_CTRL: st_nxt.rdata = {26'h0, 1'b0, st_r.ctrl[CTRL_FB_REL:0]}; // Restart bit reads 0
        REG_CONFIG: st_nxt.rdata = {24'h0, st_r.sensor, st_r.sigMode, st_r.hwRel, 1'b0, st_r.swOpt};
        REG_BUS: st_nxt.rdata = {5'h0, st_r.savedBaud, st_r.savedNode, 5'h0, st_r.baud, st_r.node};
        REG_IRQ_STAT: st_nxt.rdata = {28'h0, st_r.irqStat};
        REG_IRQ_MASK: st_nxt.rdata = {28'h0, st_r.irqMask};
        REG_STATE: st_nxt.rdata = {12'h0, st_r.faults, 2'h0, st_r.dispMode, 2'h0, st_r.menu};
        REG_HOLD: st_nxt.rdata = st_r.holdLimit;
        default: st_nxt.rdata = 32'h0;
      endcase
    end
    st_nxt.irqOut = |(st_nxt.irqStat & st_nxt.irqMask);
    // Release source follows the chosen option
    case (st_nxt.swOpt)
      SW_OFF: st_nxt.hv = 1'b0;
      SW_AUTO: st_nxt.hv = 1'b1;
      SW_KEYPAD: st_nxt.hv = st_nxt.keyRelease;
      default: st_nxt.hv = st_nxt.ctrl[CTRL_FB_REL];
    endcase
    // LED drive: item on the indicators, value on the bar
    st_nxt.bar = '0;
    st_nxt.cfg = 4'h0;
    st_nxt.mode = 4'h0;
    st_nxt.bus = 1'b0;
    st_nxt.setup = st_nxt.menu != ST_NORMAL && st_nxt.menu != ST_FLASH;
    case (st_nxt.menu)
      ST_NORMAL: st_nxt.mode = 4'h1 << st_nxt.dispMode;
      ST_SW, ST_TENS: st_nxt.cfg = 4'h1; // R08
      ST_HW, ST_ONES: st_nxt.cfg = 4'h2; // R08
      ST_SIG, ST_BAUD: st_nxt.cfg = 4'h4; // R08
      ST_SEN: st_nxt.cfg = 4'h8; // R08
      default: begin
      end
    endcase
    if ((st_nxt.menu & (ST_SW | ST_HW | ST_SIG | ST_SEN | ST_TENS | ST_ONES | ST_BAUD)) != 10'h000) begin
      st_nxt.bar = BAR_N'(1) << st_nxt.edit; // R18
    end
    if ((st_nxt.menu & (ST_TENS | ST_ONES | ST_BAUD)) != 10'h000) begin
      st_nxt.bus = 1'b1; // R14
    end
    if (st_nxt.menu == ST_FLASH && st_nxt.flashPhase[0]) begin
      st_nxt.bar = '1; // R16
      st_nxt.cfg = 4'hF;
      st_nxt.mode = 4'hF;
    end
  end

  // Single register stage for all state; reset values are constants
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.holdLimit <= 32'(HOLD_DEFAULT);
      st_r.menu <= ST_NORMAL;
      st_r.act <= ACT_SAVE;
      st_r.dispMode <= DISP_VOLT;
      st_r.swOpt <= DEF_SW;
      st_r.savedNode <= DEF_NODE;
      st_r.savedBaud <= DEF_BAUD;
      st_r.node <= DEF_NODE;
      st_r.baud <= DEF_BAUD;
      st_r.ctrl <= {1'b0, CTRL_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs are register fields
  assign regRdData = st_r.rdata;
  assign ledBar = st_r.bar;
  assign cfgLed = st_r.cfg;
  assign modeLed = st_r.mode;
  assign setupLed = st_r.setup;
  assign busLed = st_r.bus;
  assign statusLed = st_r.status;
  assign hvRelease = st_r.hv;
  assign hwReleaseEn = st_r.hwRel;
  assign signalOutMode = st_r.sigMode;
  assign sensorInMode = st_r.sensor;
  assign nodeAddr = st_r.node;
  assign baudSel = st_r.baud;
  assign savePulse = st_r.save;
  assign factoryPulse = st_r.factory;
  assign irq = st_r.irqOut;
endmodule

// ===== test/keypad_setup_menu_controller_sva.sv
// Port-level checker for the keypad and setup menu controller
module keypad_setup_menu_controller_sva #(
  parameter int HOLD_DEFAULT = 20,
  parameter int FLASH_LEN = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic keyOnOffPin,
  input wire logic sysCheckOk,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic [keypad_setup_pkg::BAR_N-1:0] ledBar,
  input wire logic [3:0] modeLed,
  input wire logic setupLed,
  input wire logic statusLed,
  input wire logic hvRelease,
  input wire logic [6:0] nodeAddr,
  input wire logic [3:0] baudSel,
  input wire logic savePulse,
  input wire logic factoryPulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Read data only stands in the cycle after a read
  property p_rd_idle;
    !$past(regRd) |-> regRdData == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
  property p_save_one;
    savePulse |=> !savePulse;
  endproperty
  a_save_one: assert property (p_save_one) else $error("save pulse too long");
  // Factory restore completes only after an on phase of the flash
  property p_fact_flash;
    factoryPulse |-> $past(ledBar) == 10'h3FF;
  endproperty
  a_fact_flash: assert property (p_fact_flash) else $error("factory without flash");
  property p_status;
    $rose(statusLed) |-> $past(sysCheckOk) || $past(sysCheckOk, 2);
  endproperty
  a_status: assert property (p_status) else $error("status lit without check");
  property p_entry;
    $rose(setupLed) |-> $past(modeLed) != 4'h4;
  endproperty
  a_entry: assert property (p_entry) else $error("menu entered from pollution view");
  property p_bar;
    $onehot0(ledBar) || ledBar == 10'h3FF;
  endproperty
  a_bar: assert property (p_bar) else $error("bar not a single position");
  // Release moves only on the key, a config apply or a register write
  property p_hv;
    $changed(hvRelease) |-> $past(keyOnOffPin, 2) || $past(keyOnOffPin, 3) || $past(keyOnOffPin, 4)
      || savePulse || $past(savePulse) || factoryPulse || $past(regWr) || $past(regWr, 2);
  endproperty
  a_hv: assert property (p_hv) else $error("release changed without cause");
  property p_node;
    $changed(nodeAddr) |-> $past(regWr) || $past(regWr, 2);
  endproperty
  a_node: assert property (p_node) else $error("node address changed before restart");
  property p_range;
    nodeAddr <= 7'h63 && baudSel <= 4'h8;
  endproperty
  a_range: assert property (p_range) else $error("node or baud out of range");
endmodule

bind keypad_setup_menu_controller keypad_setup_menu_controller_sva #(
  .HOLD_DEFAULT(HOLD_DEFAULT),
  .FLASH_LEN(FLASH_LEN)
) i_keypad_setup_menu_controller_sva (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .keyOnOffPin(keyOnOffPin),
  .sysCheckOk(sysCheckOk),
  .regWr(regWr),
  .regRd(regRd),
  .regRdData(regRdData),
  .ledBar(ledBar),
  .modeLed(modeLed),
  .setupLed(setupLed),
  .statusLed(statusLed),
  .hvRelease(hvRelease),
  .nodeAddr(nodeAddr),
  .baudSel(baudSel),
  .savePulse(savePulse),
  .factoryPulse(factoryPulse)
);

// ===== test/keypad_operator.sv
// Behavioural operator pressing the membrane keys
module keypad_operator (
  input wire logic sys_clk,
  input wire logic slowMode,
  input wire logic [5:0] keyReq,
  output logic keyPlusPin,
  output logic keyMinusPin,
  output logic keyOkPin,
  output logic keySetupPin,
  output logic displaySelectKeyPin,
  output logic keyOnOffPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] lag_r = 6'h00;
  logic [5:0] pins_r = 6'h00;
  // A slow finger reaches and leaves the keys a cycle late
  always @(posedge sys_clk) begin
    lag_r <= keyReq;
    pins_r <= slowMode ? lag_r : keyReq;
  end
  assign {keyOnOffPin, displaySelectKeyPin, keySetupPin, keyOkPin, keyMinusPin, keyPlusPin} = pins_r;
endmodule

// ===== test/tb_keypad_setup_menu_controller.sv
// Self-checking bench for the keypad and setup menu controller
module tb_keypad_setup_menu_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import keypad_setup_pkg::*;
  localparam int HOLD = 20;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic slowMode = 1'b0;
  logic [5:0] keyReq = 6'h00;
  logic faultRaise = 1'b0;
  logic sysCheckOk = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic kPlus, kMinus, kOk, kSetup, kDsel, kOnOff;
  logic [31:0] regRdData;
  logic [BAR_N-1:0] ledBar;
  logic [3:0] cfgLed, modeLed, baudSel;
  logic setupLed, busLed, statusLed, hvRelease, hwReleaseEn, sensorInMode, savePulse, factoryPulse, irq;
  logic [1:0] signalOutMode;
  logic [6:0] nodeAddr;
  int errorCnt = 0;
  int numChecks = 0;
  int seed = 76;
  int node;
  int baud;
  int cfg;

  keypad_operator i_keypad_operator (.sys_clk(sys_clk), .slowMode(slowMode), .keyReq(keyReq),
    .keyPlusPin(kPlus), .keyMinusPin(kMinus), .keyOkPin(kOk), .keySetupPin(kSetup),
    .displaySelectKeyPin(kDsel), .keyOnOffPin(kOnOff));
  keypad_setup_menu_controller #(.HOLD_DEFAULT(HOLD), .FLASH_LEN(4)) i_keypad_setup_menu_controller (
    .sys_clk(sys_clk), .reset_n(reset_n), .keyPlusPin(kPlus), .keyMinusPin(kMinus), .keyOkPin(kOk),
    .keySetupPin(kSetup), .displaySelectKeyPin(kDsel), .keyOnOffPin(kOnOff), .faultRaise(faultRaise),
    .sysCheckOk(sysCheckOk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .ledBar(ledBar), .cfgLed(cfgLed), .modeLed(modeLed), .setupLed(setupLed),
    .busLed(busLed), .statusLed(statusLed), .hvRelease(hvRelease), .hwReleaseEn(hwReleaseEn),
    .signalOutMode(signalOutMode), .sensorInMode(sensorInMode), .nodeAddr(nodeAddr), .baudSel(baudSel),
    .savePulse(savePulse), .factoryPulse(factoryPulse), .irq(irq));

  // Free-running 125 MHz clock
  initial forever #4 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    numChecks++;
    if (got !== e) begin
      errorCnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, e);
    end
  endtask
  // Register bus cycles: one strobe cycle, read data in the next
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    chk(regRdData, e);
  endtask
  // Short tap, well below the hold threshold
  task automatic press(input logic [5:0] k);
    @(posedge sys_clk);
    keyReq <= k;
    repeat (4) @(posedge sys_clk);
    keyReq <= 6'h00;
    repeat (8) @(negedge sys_clk);
  endtask
  // Hold keys until the chosen flag shows or the bound runs out
  task automatic hold_wait(input logic [5:0] k, input int sel, input logic e, input int n);
    logic f;
    f = 1'b0;
    @(posedge sys_clk);
    keyReq <= k;
    repeat (n) if (f !== 1'b1) begin
      @(negedge sys_clk);
      f = sel == 0 ? savePulse : sel == 1 ? factoryPulse : sel == 2 ? statusLed : setupLed;
    end
    chk(f, e);
    @(posedge sys_clk);
    keyReq <= 6'h00;
    repeat (8) @(posedge sys_clk);
  endtask
  // Walk the whole menu with random saturating values, then compare
  task automatic menu(input bit can);
    int mx[7] = '{4, 1, 2, 1, 9, 9, 8};
    logic [3:0] ind[7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h2, 4'h4};
    int v[7];
    hold_wait(6'h08, 3, 1'b1, 200);
    for (int i = 0; i < (can ? 7 : 4); i++) begin
      press(6'h04);
      chk(cfgLed, ind[i]);
      chk(busLed, i > 3);
      repeat (10) press(6'h02);
      v[i] = {$random(seed)} % (mx[i] + 3);
      repeat (v[i]) press(6'h01);
      if (v[i] > mx[i]) v[i] = mx[i];
      chk(ledBar, 32'h1 << v[i]);
    end
    hold_wait(6'h04, 0, 1'b1, 60);
    repeat (40) @(posedge sys_clk);
    cfg = v[0] | v[1] << 4 | v[2] << 5 | v[3] << 7;
    rd(REG_CONFIG, cfg);
    chk({sensorInMode, signalOutMode, hwReleaseEn}, cfg >> 4);
    if (can) begin
      node = v[4] * 10 + v[5];
      baud = v[6];
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    errorCnt++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(REG_CTRL, 32'h0F);
    rd(REG_CONFIG, {29'h0, SW_KEYPAD});
    rd(REG_HOLD, HOLD);
    rd(8'hFC, 32'h0);
    wr(REG_IRQ_MASK, 32'hF);
    press(6'h20);
    chk(hvRelease, 1);
    press(6'h20);
    chk(hvRelease, 0);
    hold_wait(6'h04, 0, 1'b1, 200);
    chk(irq, 1);
    rd(REG_IRQ_STAT, 32'h1);
    wr(REG_IRQ_STAT, 32'h1);
    wr(REG_IRQ_MASK, 32'h0);
    repeat (3) @(negedge sys_clk);
    chk(irq, 0);
    hold_wait(6'h07, 1, 1'b1, 200);
    chk(irq, 0);
    rd(REG_IRQ_STAT, 32'h2);
    wr(REG_IRQ_STAT, 32'h2);
    wr(REG_IRQ_MASK, 32'hF);
    repeat (2) @(posedge sys_clk) faultRaise <= 1'b1;
    @(posedge sys_clk) faultRaise <= 1'b0;
    hold_wait(6'h1C, 2, 1'b1, 200);
    rd(REG_STATE, 32'h10001);
    hold_wait(6'h1C, 0, 1'b0, 80);
    rd(REG_STATE, 32'h1);
    repeat (2) press(6'h10);
    chk(modeLed, 4'h4);
    hold_wait(6'h08, 3, 1'b0, 60);
    repeat (2) press(6'h10);
    menu(1'b1);
    chk(nodeAddr, 1);
    wr(REG_CTRL, 32'h2F);
    repeat (3) @(negedge sys_clk);
    chk(nodeAddr, node);
    chk(baudSel, baud);
    slowMode <= 1'b1;
    wr(REG_CTRL, 32'h07);
    menu(1'b0);
    tally_and_finish;
  end
endmodule
